// ===== hdl/mci_csr_window.sv
/*
 * axi4-lite register slave for the host mac: dropped frame counter,
 * indirect command/data window to the internal mac registers, interrupts
 * assumes a single clock; internal register file answers with ack on clk
 */
// The AXI4-Lite slave port was left to the implementer.
// Functional notes
// - count discarded receive frames from zero
// - reading the count returns then clears it
// - midpoint crossing sets status bit 23
// - writing busy one starts indirect transfer
// - busy holds during transfer, self-clears
// - read clears busy after data valid
// - bit 30 selects read or write
// - bits 7:0 index internal register
// - data register; write transfer copies it
// - read direction: data returns fetched value
// - write direction: data returns last written
`timescale 1ns/100ps
`default_nettype none
`include "mci_regs.svh"

module mci_csr_window (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // mac events
    input wire logic rxFrameDropped,
    // internal mac register file
    output mci_pkg::mci_csr_req_t csrReq,
    input wire mci_pkg::mci_csr_rsp_t csrRsp,
    // interrupt
    output logic irq
);
    // axi address/data holding
    logic awHeld_reg; // write address captured
    logic wHeld_reg; // write data captured
    logic [7:0] awAddr_reg; // captured write address
    logic [31:0] wData_reg; // captured write data
    logic [3:0] wStrb_reg; // captured byte strobes
    logic bvalid_reg; // write response pending
    logic [1:0] bresp_reg; // write response code
    logic rvalid_reg; // read data pending
    logic [1:0] rresp_reg; // read response code
    logic [31:0] rdata_reg; // read data
    // registers
    logic busy_reg; // indirect transfer in flight
    logic rnw_reg; // transfer direction
    logic [7:0] idx_reg; // internal register index
    logic [31:0] data_reg; // indirect data
    logic [31:0] intSts_reg; // sticky interrupt status
    logic [31:0] intMask_reg; // interrupt enables
    logic irq_reg; // interrupt line
    mci_pkg::mci_xfer_state_t state_reg; // transfer sequencer
    mci_pkg::mci_csr_req_t csrReq_reg; // request to internal file
    // decode
    logic doWrite; // write commits this cycle
    logic doRead; // read taken this cycle
    logic [31:0] wMerged; // strobe-merged write value
    logic [31:0] cmdView; // command register as read
    logic [31:0] rdMux; // read data mux
    logic rdHit; // read address mapped
    logic wrHit; // write address mapped
    logic [31:0] dropCount; // tally
    logic halfCross; // midpoint crossing pulse
    logic xferDone; // transfer finishing this cycle
    logic [31:0] intClr; // status bits cleared this cycle
    logic [31:0] intSet; // status bits set this cycle

    // byte-lane merge of a write over an old value
    function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
            input logic [31:0] newV, input logic [3:0] strb);
        logic [31:0] res;
        res = oldV;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = newV[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // mapped offset check
    function automatic logic isMapped(input logic [7:0] a);
        return (a == `MCI_OFS_DROP) || (a == `MCI_OFS_CMD) || (a == `MCI_OFS_DATA)
            || (a == `MCI_OFS_INTSTS) || (a == `MCI_OFS_INTMASK);
    endfunction

    assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
    assign doRead = s_axi_arvalid && s_axi_arready;
    assign wMerged = mergeBytes(`MCI_ZERO32, wData_reg, wStrb_reg);
    assign wrHit = isMapped(awAddr_reg);
    assign rdHit = isMapped(s_axi_araddr);
    assign xferDone = (state_reg == mci_pkg::MCI_WAIT) && csrRsp.ack;

    // reserved bits 29:8 read zero and ignore writes
    always_comb begin
        cmdView = `MCI_ZERO32;
        cmdView[`MCI_BIT_BUSY] = busy_reg;
        cmdView[`MCI_BIT_RNW] = rnw_reg;
        cmdView[`MCI_IDX_HI:0] = idx_reg;
    end

    // read data select
    always_comb begin
        case (s_axi_araddr)
            `MCI_OFS_DROP: rdMux = dropCount;
            `MCI_OFS_CMD: rdMux = cmdView;
            `MCI_OFS_DATA: rdMux = data_reg;
            `MCI_OFS_INTSTS: rdMux = intSts_reg;
            `MCI_OFS_INTMASK: rdMux = intMask_reg;
            default: rdMux = `MCI_ZERO32;
        endcase
    end

    // dropped frame tally, cleared by a taken read of its offset
    mci_drop_counter u_drop (
        .clk(clk),
        .resetn(resetn),
        .dropPulse(rxFrameDropped),
        .readClear(doRead && (s_axi_araddr == `MCI_OFS_DROP)),
        .count(dropCount),
        .halfCross(halfCross)
    );

    // write address and data capture, either order
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= `MCI_IDX_RST;
            wData_reg <= `MCI_ZERO32;
            wStrb_reg <= `MCI_STRB_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
        end
    end

    // ready flags: accept a channel only while its holding slot is free
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !awHeld_reg && !(s_axi_awvalid && s_axi_awready) && !doWrite;
            s_axi_wready <= !wHeld_reg && !(s_axi_wvalid && s_axi_wready) && !doWrite;
            s_axi_arready <= !rvalid_reg && !doRead;
        end
    end

    // write response
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `MCI_RESP_OKAY;
        end else if (doWrite) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wrHit ? `MCI_RESP_OKAY : `MCI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read response, data captured at address acceptance
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= `MCI_RESP_OKAY;
            rdata_reg <= `MCI_ZERO32;
        end else if (doRead) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rdHit ? `MCI_RESP_OKAY : `MCI_RESP_SLVERR;
            rdata_reg <= rdMux;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // command register: direction and index stored, busy set by write of one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rnw_reg <= 1'b0;
            idx_reg <= `MCI_IDX_RST;
            busy_reg <= 1'b0;
        end else begin
            if (doWrite && awAddr_reg == `MCI_OFS_CMD && !busy_reg) begin
                // writes during busy are dropped, the host must not issue them
                if (wStrb_reg[`MCI_LANE_CTL]) begin
                    rnw_reg <= wData_reg[`MCI_BIT_RNW];
                    busy_reg <= wData_reg[`MCI_BIT_BUSY];
                end
                if (wStrb_reg[`MCI_LANE_IDX]) begin
                    idx_reg <= wData_reg[`MCI_IDX_HI:0];
                end
            end else if (xferDone) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // transfer sequencer toward the internal register file
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= mci_pkg::MCI_IDLE;
            csrReq_reg <= '0;
        end else begin
            case (state_reg)
                mci_pkg::MCI_IDLE: begin
                    // only a busy command launches a transfer, data writes alone do not
                    if (busy_reg) begin
                        state_reg <= mci_pkg::MCI_ISSUE;
                    end
                end
                mci_pkg::MCI_ISSUE: begin
                    csrReq_reg.req <= 1'b1;
                    csrReq_reg.rnw <= rnw_reg;
                    csrReq_reg.idx <= idx_reg;
                    csrReq_reg.wdata <= data_reg;
                    state_reg <= mci_pkg::MCI_WAIT;
                end
                mci_pkg::MCI_WAIT: begin
                    if (csrRsp.ack) begin
                        csrReq_reg.req <= 1'b0;
                        state_reg <= mci_pkg::MCI_IDLE;
                    end
                end
                default: state_reg <= mci_pkg::MCI_IDLE;
            endcase
        end
    end

    // data register: host writes when idle, read fetch lands with busy clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_reg <= `MCI_ZERO32;
        end else if (xferDone && csrReq_reg.rnw) begin
            data_reg <= csrRsp.rdata;
        end else if (doWrite && awAddr_reg == `MCI_OFS_DATA && !busy_reg) begin
            data_reg <= mergeBytes(data_reg, wData_reg, wStrb_reg);
        end
    end

    // status events and write-one clears of this cycle
    always_comb begin
        intClr = (doWrite && awAddr_reg == `MCI_OFS_INTSTS) ? wMerged : `MCI_ZERO32;
        intSet = `MCI_ZERO32;
        intSet[`MCI_BIT_HALF] = halfCross;
        intSet[`MCI_BIT_DONE] = xferDone;
    end

    // sticky interrupt status, write one to clear, set wins over clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intSts_reg <= `MCI_ZERO32;
        end else begin
            intSts_reg <= ((intSts_reg & ~intClr) | intSet) & `MCI_INT_MASK_VALID;
        end
    end

    // interrupt mask and output line
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            intMask_reg <= `MCI_ZERO32;
            irq_reg <= 1'b0;
        end else begin
            if (doWrite && awAddr_reg == `MCI_OFS_INTMASK) begin
                intMask_reg <= mergeBytes(intMask_reg, wData_reg, wStrb_reg)
                    & `MCI_INT_MASK_VALID;
            end
            irq_reg <= |(intSts_reg & intMask_reg);
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign csrReq = csrReq_reg;
    assign irq = irq_reg;

    // a command write of busy one is seen as busy next cycle
    sequence s_startCmd;
        doWrite && awAddr_reg == `MCI_OFS_CMD && !busy_reg && wStrb_reg[`MCI_LANE_CTL]
            && wData_reg[`MCI_BIT_BUSY];
    endsequence
    a_busy_starts: assert property (@(posedge clk) disable iff (!resetn)
        s_startCmd |=> busy_reg ##2 csrReq_reg.req)
        else $error("busy write did not start transfer");
    a_busy_holds: assert property (@(posedge clk) disable iff (!resetn)
        busy_reg && !xferDone |=> busy_reg)
        else $error("busy dropped before completion");
    a_busy_clears: assert property (@(posedge clk) disable iff (!resetn)
        xferDone |=> !busy_reg)
        else $error("busy not cleared after completion");
    a_read_data_valid: assert property (@(posedge clk) disable iff (!resetn)
        xferDone && csrReq_reg.rnw |=> data_reg == $past(csrRsp.rdata))
        else $error("read data not loaded with busy clear");
    a_write_copies: assert property (@(posedge clk) disable iff (!resetn)
        csrReq_reg.req && !csrReq_reg.rnw |-> csrReq_reg.wdata == data_reg)
        else $error("write transfer data mismatch");
    a_no_stray_req: assert property (@(posedge clk) disable iff (!resetn)
        csrReq_reg.req |-> busy_reg)
        else $error("internal access without busy");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
        doRead && s_axi_araddr == `MCI_OFS_CMD |=> rdata_reg[`MCI_RSV_HI:`MCI_RSV_LO] == '0)
        else $error("reserved command bits not zero");
    a_half_flag: assert property (@(posedge clk) disable iff (!resetn)
        halfCross |=> intSts_reg[`MCI_BIT_HALF])
        else $error("midpoint flag not set");
    a_dir_stored: assert property (@(posedge clk) disable iff (!resetn)
        s_startCmd |=> rnw_reg == $past(wData_reg[`MCI_BIT_RNW]))
        else $error("direction not stored");
endmodule
`default_nettype wire

// ===== hdl/mci_regs.svh
/*
 * register offsets, field positions and reset values of the mac csr window
 * assumes inclusion by bare name from the design files and the bench
 */
`ifndef MCI_REGS_SVH
`define MCI_REGS_SVH

`define MCI_OFS_DROP 8'ha0
`define MCI_OFS_CMD 8'ha4
`define MCI_OFS_DATA 8'ha8
`define MCI_OFS_INTSTS 8'hb0
`define MCI_OFS_INTMASK 8'hb4
`define MCI_BIT_BUSY 31
`define MCI_BIT_RNW 30
`define MCI_IDX_HI 7
`define MCI_RSV_HI 29
`define MCI_RSV_LO 8
`define MCI_LANE_CTL 3
`define MCI_LANE_IDX 0
`define MCI_STRB_RST 4'h0
`define MCI_BIT_HALF 23
`define MCI_BIT_DONE 0
`define MCI_CNT_MID 32'h7fffffff
`define MCI_ZERO32 32'h00000000
`define MCI_ONE32 32'h00000001
`define MCI_IDX_RST 8'h00
`define MCI_RESP_OKAY 2'h0
`define MCI_RESP_SLVERR 2'h2
`define MCI_INT_MASK_VALID 32'h00800001

`endif

// ===== hdl/mci_pkg.sv
/*
 * types shared by the mac csr window design
 * assumes mci_regs.svh is on the include path
 */
`default_nettype none
package mci_pkg;
    // request to the internal mac register file
    typedef struct packed {
        logic req;
        logic rnw;
        logic [7:0] idx;
        logic [31:0] wdata;
    } mci_csr_req_t;

    // answer from the internal mac register file
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } mci_csr_rsp_t;

    // indirect transfer sequencer states
    typedef enum logic [1:0] {
        MCI_IDLE,
        MCI_ISSUE,
        MCI_WAIT
    } mci_xfer_state_t;
endpackage
`default_nettype wire

// ===== hdl/mci_drop_counter.sv
/*
 * dropped receive frame counter, cleared on read, flags its midpoint crossing
 * assumes dropPulse and readClear come from logic on the same clock
 */
`timescale 1ns/100ps
`default_nettype none
`include "mci_regs.svh"

module mci_drop_counter (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // events
    input wire logic dropPulse,
    input wire logic readClear,
    // state
    output logic [31:0] count,
    output logic halfCross
);
    logic [31:0] count_reg; // running tally
    logic halfCross_reg; // one-cycle midpoint crossing

    // count up per drop; a read zeroes it, a drop in the same cycle counts as one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= `MCI_ZERO32;
        end else if (readClear) begin
            count_reg <= dropPulse ? `MCI_ONE32 : `MCI_ZERO32;
        end else if (dropPulse) begin
            count_reg <= count_reg + `MCI_ONE32;
        end
    end

    // pulse when the tally steps from the midpoint to the next value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            halfCross_reg <= 1'b0;
        end else begin
            halfCross_reg <= dropPulse && !readClear && (count_reg == `MCI_CNT_MID);
        end
    end

    assign count = count_reg;
    assign halfCross = halfCross_reg;

    a_drop_increments: assert property (@(posedge clk) disable iff (!resetn)
        dropPulse && !readClear |=> count_reg == $past(count_reg) + `MCI_ONE32)
        else $error("drop did not increment tally");
    a_read_clears: assert property (@(posedge clk) disable iff (!resetn)
        readClear && !dropPulse |=> count_reg == `MCI_ZERO32)
        else $error("read did not clear tally");
endmodule
`default_nettype wire

// ===== test/mci_csr_file_model.sv
/*
 * behavioural model of the internal mac register file behind the window
 * assumes req holds steady until ack and everything runs on one clock
 */
`timescale 1ns/100ps
`default_nettype none

module mci_csr_file_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // answer pacing chosen by the bench
    input wire logic slow,
    // link to the window
    input wire mci_pkg::mci_csr_req_t req,
    output mci_pkg::mci_csr_rsp_t rsp,
    // count of internal writes seen
    output logic [31:0] writeCount
);
    localparam int SlowWait = 20; // cycles of delay when slow
    logic [31:0] memReg [256]; // internal register contents
    int waitCnt; // cycles spent before answering

    // known preload so fetched values can be predicted
    initial begin
        for (int i = 0; i < 256; i++) memReg[i] = 32'hcafe0000 | 32'(i);
    end

    // answer one request at a time, promptly or slowly
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp <= '0;
            waitCnt <= 0;
            writeCount <= 32'h00000000;
        end else begin
            rsp.ack <= 1'b0;
            // data outside ack keeps changing, never stale
            rsp.rdata <= ~rsp.rdata;
            if (req.req && !rsp.ack) begin
                if (waitCnt >= (slow ? SlowWait : 0)) begin
                    rsp.ack <= 1'b1;
                    waitCnt <= 0;
                    if (req.rnw) begin
                        rsp.rdata <= memReg[req.idx];
                    end else begin
                        memReg[req.idx] <= req.wdata;
                        writeCount <= writeCount + 32'h00000001;
                    end
                end else begin
                    waitCnt <= waitCnt + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/test_mac_csr_indirect_access.sv
/*
 * self-checking bench for the mac csr window over axi4-lite
 * assumes the window's design files and the register file model are compiled first
 */
`timescale 1ns/100ps
`default_nettype none
`include "mci_regs.svh"

module test_mac_csr_indirect_access;
    // one ordinary read case: address, response, data
    typedef struct {logic [7:0] addr; logic [1:0] resp; logic [31:0] data;} mci_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    // axi4-lite master side
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    // events, internal link and interrupt
    logic rxFrameDropped = 1'b0;
    logic slow = 1'b0;
    mci_pkg::mci_csr_req_t csrReq;
    mci_pkg::mci_csr_rsp_t csrRsp;
    logic irq;
    logic [31:0] writeCount;
    // bookkeeping
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic seenBusy;
    // values right after reset, plus an unmapped place
    mci_row_t rows [6] = '{'{`MCI_OFS_DROP, 2'h0, 32'h0}, '{`MCI_OFS_CMD, 2'h0, 32'h0},
        '{`MCI_OFS_DATA, 2'h0, 32'h0}, '{`MCI_OFS_INTSTS, 2'h0, 32'h0},
        '{`MCI_OFS_INTMASK, 2'h0, 32'h0}, '{8'hfc, 2'h2, 32'h0}};

    mci_csr_window mci_csr_window_i (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rxFrameDropped(rxFrameDropped), .csrReq(csrReq), .csrRsp(csrRsp), .irq(irq));

    mci_csr_file_model mci_csr_file_model_i (.clk(clk), .resetn(resetn), .slow(slow),
        .req(csrReq), .rsp(csrRsp), .writeCount(writeCount));

    // 50 mhz clock
    always #10 clk = ~clk;

    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // counts, verdict, end of run
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one comparison of a word
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task test_end(input string name);
        $display("test done: %s", name);
    endtask

    // one write: address and data offered together, each released when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic awOpen, wOpen;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awOpen = 1'b1;
        wOpen = 1'b1;
        do begin
            @(posedge clk);
            if (awOpen && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                awOpen = 1'b0;
            end
            if (wOpen && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                wOpen = 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // one read: address held until taken, data taken with rvalid
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // poll the command word until busy drops, noting busy on the first look
    task automatic wait_idle(output logic busySeen);
        int n = 0;
        busySeen = 1'b0;
        rd = 32'h80000000;
        while (rd[31] !== 1'b0 && n < 40) begin
            axi_read(`MCI_OFS_CMD, rd, rs);
            if (n == 0) busySeen = rd[31];
            n++;
        end
        chk("busy cleared", 32'h00000000, {31'h0, rd[31]});
    endtask

    task pulse_drops(input int k);
        repeat (k) begin
            @(posedge clk);
            rxFrameDropped <= 1'b1;
            @(posedge clk);
            rxFrameDropped <= 1'b0;
        end
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // reset values and the unmapped place
        foreach (rows[i]) begin
            axi_read(rows[i].addr, rd, rs);
            chk("read resp", {30'h0, rows[i].resp}, {30'h0, rs});
            chk("read data", rows[i].data, rd);
        end
        axi_write(8'hfc, 32'hffffffff, rs);
        chk("unmapped write resp", 32'h00000002, {30'h0, rs});
        test_end("reset values");
        // counting and clear on read
        pulse_drops(3);
        repeat (2) @(posedge clk);
        axi_read(`MCI_OFS_DROP, rd, rs);
        chk("drop count", 32'h00000003, rd);
        axi_read(`MCI_OFS_DROP, rd, rs);
        chk("drop after read", 32'h00000000, rd);
        test_end("drop counter");
        // command fields with busy clear start nothing
        axi_write(`MCI_OFS_CMD, 32'h7fffff12, rs);
        chk("cmd write resp", 32'h00000000, {30'h0, rs});
        axi_read(`MCI_OFS_CMD, rd, rs);
        chk("command fields", 32'h40000012, rd);
        // plain data write is stored only
        axi_write(`MCI_OFS_DATA, 32'h12345678, rs);
        chk("internal writes", 32'h00000000, writeCount);
        axi_write(`MCI_OFS_CMD, 32'h80000005, rs);
        wait_idle(seenBusy);
        chk("internal reg 5", 32'h12345678, mci_csr_file_model_i.memReg[5]);
        chk("internal writes", 32'h00000001, writeCount);
        axi_read(`MCI_OFS_DATA, rd, rs);
        chk("data after write", 32'h12345678, rd);
        test_end("indirect write");
        // done status raises irq only when unmasked
        axi_read(`MCI_OFS_INTSTS, rd, rs);
        chk("status done", 32'h00000001, rd);
        chk("irq masked", 32'h00000000, {31'h0, irq});
        axi_write(`MCI_OFS_INTMASK, 32'h00000001, rs);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h00000001, {31'h0, irq});
        axi_write(`MCI_OFS_INTSTS, 32'h00000001, rs);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h00000000, {31'h0, irq});
        test_end("interrupt");
        // slow indirect read, with a data write while busy
        slow <= 1'b1;
        axi_write(`MCI_OFS_CMD, 32'hc0000033, rs);
        axi_write(`MCI_OFS_DATA, 32'hffff0000, rs);
        chk("write while busy resp", 32'h00000000, {30'h0, rs});
        wait_idle(seenBusy);
        chk("busy while pending", 32'h00000001, {31'h0, seenBusy});
        axi_read(`MCI_OFS_DATA, rd, rs);
        chk("fetched data", 32'hcafe0033, rd);
        axi_read(`MCI_OFS_CMD, rd, rs);
        chk("command after read", 32'h40000033, rd);
        chk("internal writes", 32'h00000001, writeCount);
        test_end("indirect read");
        // reset in mid-run clears the tally
        pulse_drops(2);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        axi_read(`MCI_OFS_DROP, rd, rs);
        chk("drop after reset", 32'h00000000, rd);
        test_end("mid-run reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
